// >>> hdl/dbg_link_params.svh
// Offsets, codes and field positions for the two-wire debug register layer
`ifndef DBG_LINK_PARAMS_SVH
`define DBG_LINK_PARAMS_SVH

// ****************************************************************
// Target-select codes
// ****************************************************************
`define SEL_PART_IDENTITY     8'h00
`define SEL_SILICON_REVISION  8'h01
`define SEL_PROGRAM_CONTROL   8'h02
`define SEL_PROGRAM_DATA      8'hB4
`define SEL_RESET             8'h00

// ****************************************************************
// Programming control unlock codes and reset value
// ****************************************************************
`define UNLOCK_FIRST          8'h02
`define UNLOCK_SECOND         8'h01
`define PROGRAM_CONTROL_RESET 8'h00

// ****************************************************************
// Flash command codes on the program data port
// ****************************************************************
`define CMD_BLOCK_READ        8'h06
`define CMD_BLOCK_WRITE       8'h07
`define CMD_PAGE_ERASE        8'h08
`define CMD_DEVICE_ERASE      8'h03

// Bit positions in the one-hot command strobe
`define CMD_BIT_READ          0
`define CMD_BIT_WRITE         1
`define CMD_BIT_PAGE_ERASE    2
`define CMD_BIT_DEVICE_ERASE  3

// ****************************************************************
// Frame layout
// ****************************************************************
`define INS_BITS              2'h2
`define DATA_BITS             4'h8

// Arbitrary identity value, not tied to any real part
`define PART_IDENTITY_VALUE   8'h5A

`endif

// >>> hdl/dbg_link_pkg.sv
// Types shared by the debug register layer
package dbg_link_pkg;

  // Link frame states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_INS   = 4'h2,
    ST_WDATA = 4'h4,
    ST_RDATA = 4'h8
  } link_state_t;

  // Two-bit instruction sent after the start bit in a frame, LSB first
  typedef enum logic [1:0] {
    INS_DATA_READ  = 2'h0,
    INS_ADDR_WRITE = 2'h1,
    INS_DATA_WRITE = 2'h2,
    INS_ADDR_READ  = 2'h3
  } link_ins_t;

endpackage

// >>> hdl/pin_filter.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps

module pin_filter (
  // Clock and reset
  input  wire logic MCLK,
  input  wire logic NRST,
  // Asynchronous pin
  input  wire logic PIN,
  // Clean level and edges
  output logic      LEVEL,
  output logic      RISE,
  output logic      FALL,
  // Level the pin rests at between uses
  input  wire logic IDLE_LEVEL
);

  logic       s1_ff;      // First stage, read only by s2
  logic       s2_ff;      // Second stage
  logic       s3_ff;      // Third stage
  logic       lvl_ff;     // Accepted level
  logic       nxt_lvl;
  logic       rise_ff;    // One-cycle rising pulse
  logic       fall_ff;    // One-cycle falling pulse
  logic       nxt_rise;
  logic       nxt_fall;
  logic [2:0] fill_ff;    // Cycles since reset, stops at four
  logic [2:0] nxt_fill;
  logic       primed;     // All stages hold real pin samples

  // Stages start from reset values, not from the pin
  assign primed = (fill_ff == 3'h4);

  // ****************************************************************
  // Next level: change only once stages two and three agree
  // ****************************************************************
  always_comb begin
    nxt_lvl  = lvl_ff;
    nxt_rise = 1'b0;
    nxt_fall = 1'b0;
    nxt_fill = primed ? fill_ff : fill_ff + 3'h1;
    if (s2_ff == s3_ff && s3_ff != lvl_ff) begin
      nxt_lvl  = s3_ff;
      // Before priming, a step toward the idle level is only reset catching up
      nxt_rise = s3_ff & (primed | ~IDLE_LEVEL);
      nxt_fall = ~s3_ff & (primed | IDLE_LEVEL);
    end
  end

  // Registers; reset leaves everything low, the pin idle level is not known yet
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      lvl_ff  <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
      fill_ff <= 3'h0;
    end else begin
      s1_ff   <= PIN;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      lvl_ff  <= nxt_lvl;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
      fill_ff <= nxt_fill;
    end
  end

  assign LEVEL = lvl_ff;
  assign RISE  = rise_ff;
  assign FALL  = fall_ff;

endmodule

// >>> hdl/dbg_link_regs.sv
// Target-side register layer of the two-wire debug and programming port
`timescale 1ns/10ps
`include "dbg_link_params.svh"

module dbg_link_regs (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       NRST,
  // Debug pins
  input  wire logic       DEBUG_CLOCK_PIN,
  input  wire logic       DEBUG_DATA_PIN_IN,
  output logic            DEBUG_DATA_PIN_OUT,
  output logic            DEBUG_DATA_PIN_OE_N,
  // Die revision strap
  input  wire logic [7:0] SILICON_REV,
  // Flash engine side
  input  wire logic [7:0] PROG_RDATA,
  input  wire logic       CMD_EXPECT,
  output logic            PROG_MODE,
  output logic [7:0]      PROG_WDATA,
  output logic            PROG_WR_STB,
  output logic            PROG_RD_STB,
  output logic [3:0]      FLASH_CMD
);

  // ****************************************************************
  // Pin conditioning
  // ****************************************************************
  logic clk_rise;   // Host clock rising: sample data
  logic clk_fall;   // Host clock falling: device drives next bit
  logic data_lvl;   // Clean data line level

  // A host clock parked high through reset gives no false rising edge
  // Host clock idles high between frames
  pin_filter u_clk_filter (
    .MCLK       (MCLK),
    .NRST       (NRST),
    .PIN        (DEBUG_CLOCK_PIN),
    .LEVEL      (),
    .RISE       (clk_rise),
    .FALL       (clk_fall),
    .IDLE_LEVEL (1'b1)
  );

  // Data line sampled through the same depth so it aligns with clock edges
  pin_filter u_data_filter (
    .MCLK       (MCLK),
    .NRST       (NRST),
    .PIN        (DEBUG_DATA_PIN_IN),
    .LEVEL      (data_lvl),
    .RISE       (),
    .FALL       (),
    .IDLE_LEVEL (1'b1)   // Pull-up holds the idle wire high
  );

  // ****************************************************************
  // Register state
  // ****************************************************************
  // Each register except rev_ff and rev_done_ff pairs with the next value computed for it below
  dbg_link_pkg::link_state_t state_ff;   // Frame state
  dbg_link_pkg::link_state_t nxt_state;
  logic [1:0] ins_ff;                    // Instruction being received
  logic [1:0] nxt_ins;
  logic [3:0] cnt_ff;                    // Bit counter within a field
  logic [3:0] nxt_cnt;
  logic [7:0] shift_ff;                  // Data shifter, LSB first
  logic [7:0] nxt_shift;
  logic [7:0] sel_ff;                    // Target select
  logic [7:0] nxt_sel;
  logic [7:0] ctl_ff;                    // Programming control byte
  logic [7:0] nxt_ctl;
  logic       armed_ff;                  // First unlock code seen
  logic       nxt_armed;
  logic       prog_ff;                   // Programming mode, sticky
  logic       nxt_prog;
  logic [7:0] wdata_ff;                  // Byte handed to the flash engine
  logic [7:0] nxt_wdata;
  logic       wr_stb_ff;
  logic       nxt_wr_stb;
  logic       rd_stb_ff;
  logic       nxt_rd_stb;
  logic [3:0] cmd_ff;                    // One-hot command strobe
  logic [3:0] nxt_cmd;
  logic       dout_ff;                   // Data pin output bit
  logic       nxt_dout;
  logic       oe_n_ff;                   // Data pin enable, low drives
  logic       nxt_oe_n;
  logic [7:0] rev_ff;                    // Captured revision strap
  logic       rev_done_ff;               // Strap captured since reset
  logic [7:0] rd_value;                  // Value a data read returns
  logic [7:0] wr_byte;                   // Completed write byte

  // ****************************************************************
  // Read selection
  // ****************************************************************
  // Data-port reads take whatever the engine offers at launch
  // Unselected codes read as zero rather than floating garbage
  always_comb begin
    unique case (sel_ff)
      `SEL_PART_IDENTITY:    rd_value = `PART_IDENTITY_VALUE;
      `SEL_SILICON_REVISION: rd_value = rev_ff;
      `SEL_PROGRAM_CONTROL:  rd_value = ctl_ff;
      `SEL_PROGRAM_DATA:     rd_value = PROG_RDATA;
      default:               rd_value = 8'h00;
    endcase
  end

  // Last write bit joins the shifter from the top
  assign wr_byte = {data_lvl, shift_ff[7:1]};

  // ****************************************************************
  // Frame engine and register writes
  // ****************************************************************
  always_comb begin
    nxt_state  = state_ff;
    nxt_ins    = ins_ff;
    nxt_cnt    = cnt_ff;
    nxt_shift  = shift_ff;
    nxt_sel    = sel_ff;
    nxt_ctl    = ctl_ff;
    nxt_armed  = armed_ff;
    nxt_prog   = prog_ff;
    nxt_wdata  = wdata_ff;
    nxt_wr_stb = 1'b0;
    nxt_rd_stb = 1'b0;
    nxt_cmd    = 4'h0;
    nxt_dout   = dout_ff;
    nxt_oe_n   = oe_n_ff;
    unique case (state_ff)
      // Start bit: data low at a rising clock edge
      dbg_link_pkg::ST_IDLE: begin
        // Line stays released while waiting for a start bit
        nxt_oe_n = 1'b1;
        if (clk_rise && !data_lvl) begin
          nxt_state = dbg_link_pkg::ST_INS;
          nxt_cnt   = 4'h0;
        end
      end
      // Two instruction bits, LSB first
      dbg_link_pkg::ST_INS: begin
        if (clk_rise) begin
          nxt_ins = {data_lvl, ins_ff[1]};
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff[1:0] == `INS_BITS - 2'h1) begin
            nxt_cnt = 4'h0;
            unique case ({data_lvl, ins_ff[1]})
              dbg_link_pkg::INS_DATA_READ: begin
                nxt_shift  = rd_value;
                nxt_rd_stb = (sel_ff == `SEL_PROGRAM_DATA);
                nxt_state  = dbg_link_pkg::ST_RDATA;
              end
              dbg_link_pkg::INS_ADDR_READ: begin
                nxt_shift = sel_ff;
                nxt_state = dbg_link_pkg::ST_RDATA;
              end
              // Select writes and data writes both take eight host bits
              default: begin
                nxt_state = dbg_link_pkg::ST_WDATA;
              end
            endcase
          end
        end
      end
      // Eight bits from the host, then commit
      dbg_link_pkg::ST_WDATA: begin
        if (clk_rise) begin
          nxt_shift = wr_byte;
          nxt_cnt   = cnt_ff + 4'h1;
          if (cnt_ff == `DATA_BITS - 4'h1) begin
            nxt_state = dbg_link_pkg::ST_IDLE;
            // Select writes land whatever the current target is
            if (ins_ff == dbg_link_pkg::INS_ADDR_WRITE) begin
              nxt_sel = wr_byte;
            end else begin
              unique case (sel_ff)
                `SEL_PROGRAM_CONTROL: begin
                  nxt_ctl = wr_byte;
                  // Any other byte breaks the unlock order
                  nxt_armed = (wr_byte == `UNLOCK_FIRST);
                  if (armed_ff && wr_byte == `UNLOCK_SECOND) begin
                    nxt_prog = 1'b1;
                  end
                end
                `SEL_PROGRAM_DATA: begin
                  // The engine sees every byte; only some of them are commands
                  nxt_wdata  = wr_byte;
                  nxt_wr_stb = 1'b1;
                  // Commands only count where the engine waits for one
                  if (prog_ff && CMD_EXPECT) begin
                    nxt_cmd[`CMD_BIT_READ]         = (wr_byte == `CMD_BLOCK_READ);
                    nxt_cmd[`CMD_BIT_WRITE]        = (wr_byte == `CMD_BLOCK_WRITE);
                    nxt_cmd[`CMD_BIT_PAGE_ERASE]   = (wr_byte == `CMD_PAGE_ERASE);
                    nxt_cmd[`CMD_BIT_DEVICE_ERASE] = (wr_byte == `CMD_DEVICE_ERASE);
                  end
                end
                // Identity, revision and unknown codes drop the byte
                default: begin
                  nxt_ctl = ctl_ff;
                end
              endcase
            end
          end
        end
      end
      // Device drives a bit after each falling edge; host samples on rise
      dbg_link_pkg::ST_RDATA: begin
        // Falls launch bits; rises count bits the host has taken
        if (clk_fall && cnt_ff != `DATA_BITS) begin
          nxt_dout  = shift_ff[0];
          nxt_oe_n  = 1'b0;
          nxt_shift = {1'b0, shift_ff[7:1]};
        end
        // A rise before the first bit is on the wire is not counted
        if (clk_rise && !oe_n_ff) begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == `DATA_BITS - 4'h1) begin
            // Release the line once the host has taken the last bit
            nxt_oe_n  = 1'b1;
            nxt_state = dbg_link_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  // Register the frame engine; programming mode only leaves on NRST
  // Nothing is decided here; this block only registers the values above
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_ff  <= dbg_link_pkg::ST_IDLE;
      ins_ff    <= 2'h0;
      cnt_ff    <= 4'h0;
      shift_ff  <= 8'h00;
      sel_ff    <= `SEL_RESET;
      ctl_ff    <= `PROGRAM_CONTROL_RESET;
      armed_ff  <= 1'b0;
      prog_ff   <= 1'b0;
      wdata_ff  <= 8'h00;
      wr_stb_ff <= 1'b0;
      rd_stb_ff <= 1'b0;
      cmd_ff    <= 4'h0;
      dout_ff   <= 1'b0;
      oe_n_ff   <= 1'b1;
    end else begin
      state_ff  <= nxt_state;
      ins_ff    <= nxt_ins;
      cnt_ff    <= nxt_cnt;
      shift_ff  <= nxt_shift;
      sel_ff    <= nxt_sel;
      ctl_ff    <= nxt_ctl;
      armed_ff  <= nxt_armed;
      prog_ff   <= nxt_prog;
      wdata_ff  <= nxt_wdata;
      wr_stb_ff <= nxt_wr_stb;
      rd_stb_ff <= nxt_rd_stb;
      cmd_ff    <= nxt_cmd;
      dout_ff   <= nxt_dout;
      oe_n_ff   <= nxt_oe_n;
    end
  end

  // ****************************************************************
  // Revision strap capture
  // ****************************************************************
  // Caught once after reset release; the strap is static on a given die
  // Limitation: a strap that moves later is only seen after the next reset
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rev_ff      <= 8'h00;
      rev_done_ff <= 1'b0;
    end else if (!rev_done_ff) begin
      rev_ff      <= SILICON_REV;
      rev_done_ff <= 1'b1;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Only the pins reach these registers, no processor path exists
  assign DEBUG_DATA_PIN_OUT  = dout_ff;
  assign DEBUG_DATA_PIN_OE_N = oe_n_ff;
  // Flash engine side, every output straight from a flip-flop
  assign PROG_MODE           = prog_ff;
  assign PROG_WDATA          = wdata_ff;
  assign PROG_WR_STB         = wr_stb_ff;
  assign PROG_RD_STB         = rd_stb_ff;
  assign FLASH_CMD           = cmd_ff;

endmodule

// >>> tb/dbg_link_regs_chk.sv
// Port-level checks for the debug register layer
`timescale 1ns/10ps
`include "dbg_link_params.svh"

module dbg_link_regs_chk (
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       NRST,
  // Link side
  input wire logic       DEBUG_CLOCK_PIN,
  input wire logic       DEBUG_DATA_PIN_OE_N,
  // Flash engine side
  input wire logic       PROG_MODE,
  input wire logic [7:0] PROG_WDATA,
  input wire logic       PROG_WR_STB,
  input wire logic       PROG_RD_STB,
  input wire logic [3:0] FLASH_CMD
);
  // ********************
  // Sequences
  // ********************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  // Host clock parked high well past any bit
  sequence link_idle;
    DEBUG_CLOCK_PIN [*8];
  endsequence
  // A read of the data port has launched
  sequence read_launch;
    PROG_RD_STB;
  endsequence

  // ********************
  // Assertions
  // ********************
  wr_pulse_a: assert property (PROG_WR_STB |=> !PROG_WR_STB)
    else $error("write strobe longer than one cycle");
  rd_pulse_a: assert property (PROG_RD_STB |=> !PROG_RD_STB)
    else $error("read strobe longer than one cycle");
  rd_drive_a: assert property (read_launch |-> ##[1:16] !DEBUG_DATA_PIN_OE_N)
    else $error("device did not drive after read launch");
  link_quiet_a: assert property (link_idle |-> ##4 DEBUG_DATA_PIN_OE_N)
    else $error("device drives data wire while link idle");
  cmd_mode_a: assert property (FLASH_CMD != 4'h0 |-> PROG_MODE && PROG_WR_STB)
    else $error("command pulse outside programming write");
  cmd_decode_a: assert property (FLASH_CMD != 4'h0 |-> FLASH_CMD == {
    PROG_WDATA == `CMD_DEVICE_ERASE, PROG_WDATA == `CMD_PAGE_ERASE,
    PROG_WDATA == `CMD_BLOCK_WRITE, PROG_WDATA == `CMD_BLOCK_READ})
    else $error("command pulse does not match byte");
  mode_hold_a: assert property (PROG_MODE |=> PROG_MODE)
    else $error("programming mode left without reset");
  wdata_hold_a: assert property (!PROG_WR_STB |-> PROG_WDATA == $past(PROG_WDATA))
    else $error("write data changed without strobe");
endmodule

bind dbg_link_regs dbg_link_regs_chk dbg_link_regs_chk_i (
  .MCLK(MCLK), .NRST(NRST), .DEBUG_CLOCK_PIN(DEBUG_CLOCK_PIN),
  .DEBUG_DATA_PIN_OE_N(DEBUG_DATA_PIN_OE_N), .PROG_MODE(PROG_MODE),
  .PROG_WDATA(PROG_WDATA), .PROG_WR_STB(PROG_WR_STB), .PROG_RD_STB(PROG_RD_STB),
  .FLASH_CMD(FLASH_CMD));

// >>> tb/dbg_host_model.sv
// Behavioural debug host driving the two-wire link
`timescale 1ns/10ps

module dbg_host_model (
  // Link pins seen by the device
  output logic      DEBUG_CLOCK_PIN,
  output logic      DEBUG_DATA_PIN_IN,
  // Device drive of the shared wire
  input  wire logic DEBUG_DATA_PIN_OUT,
  input  wire logic DEBUG_DATA_PIN_OE_N
);
  logic host_oe;  // Host drives the wire
  logic host_bit; // Bit the host drives

  // Wire level: device, else host, else pull-up
  assign DEBUG_DATA_PIN_IN = !DEBUG_DATA_PIN_OE_N ? DEBUG_DATA_PIN_OUT :
                             (host_oe ? host_bit : 1'b1);

  // Clock idles high; it only moves inside frames
  initial begin
    DEBUG_CLOCK_PIN = 1'b1;
    host_oe = 1'b0;
    host_bit = 1'b1;
  end

  // One host bit, data changed while clock low
  task automatic send(input logic b);
    DEBUG_CLOCK_PIN = 1'b0;
    host_bit = b;
    #32;
    DEBUG_CLOCK_PIN = 1'b1;
    #32;
  endtask

  // Start bit, two instruction bits, eight data bits LSB first
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    rd = 8'h00;
    host_oe = 1'b1;
    send(1'b0);
    send(ins[0]);
    send(ins[1]);
    for (int k = 0; k < 8; k++) begin
      if (ins[0] == ins[1]) begin
        // Read: release, sample late since device lags the fall
        DEBUG_CLOCK_PIN = 1'b0;
        host_oe = 1'b0;
        #32;
        DEBUG_CLOCK_PIN = 1'b1;
        #28;
        rd[k] = DEBUG_DATA_PIN_IN;
        #4;
      end else begin
        send(wd[k]);
      end
    end
    host_oe = 1'b0;
  endtask
endmodule

// >>> tb/tb_dbg_link_regs.sv
// Self-checking bench for the debug register layer
`timescale 1ns/10ps
`include "dbg_link_params.svh"

module tb_dbg_link_regs;
  // ********************
  // Signals
  // ********************
  localparam logic [1:0] SEL_WR = dbg_link_pkg::INS_ADDR_WRITE;
  localparam logic [1:0] SEL_RD = dbg_link_pkg::INS_ADDR_READ;
  localparam logic [1:0] DAT_WR = dbg_link_pkg::INS_DATA_WRITE;
  localparam logic [1:0] DAT_RD = dbg_link_pkg::INS_DATA_READ;
  logic       mclk, nrst, dbg_clk, dbg_in, dbg_out, dbg_oe_n;
  logic       cmd_expect, prog_mode, prog_wr_stb, prog_rd_stb;
  logic [7:0] rev, prog_rdata, prog_wdata;
  logic [3:0] flash_cmd;
  logic [3:0] cmd_seen;     // Command pulses since last clear
  logic [7:0] wr_cnt;       // Write strobes since last clear
  logic [7:0] rd_cnt;       // Read strobes since last clear
  logic       clr;          // Empties the strobe tallies
  logic [7:0] got;          // Last byte read over the link
  logic [7:0] v;            // Byte under test
  logic [7:0] tbl [4];      // Command codes
  integer     seed;         // Fixed seed keeps runs repeatable
  int         fails;
  int         n_compared;

  dbg_link_regs dbg_link_regs_i (
    .MCLK(mclk), .NRST(nrst), .DEBUG_CLOCK_PIN(dbg_clk), .DEBUG_DATA_PIN_IN(dbg_in),
    .DEBUG_DATA_PIN_OUT(dbg_out), .DEBUG_DATA_PIN_OE_N(dbg_oe_n), .SILICON_REV(rev),
    .PROG_RDATA(prog_rdata), .CMD_EXPECT(cmd_expect), .PROG_MODE(prog_mode),
    .PROG_WDATA(prog_wdata), .PROG_WR_STB(prog_wr_stb), .PROG_RD_STB(prog_rd_stb),
    .FLASH_CMD(flash_cmd));
  dbg_host_model dbg_host_model_i (
    .DEBUG_CLOCK_PIN(dbg_clk), .DEBUG_DATA_PIN_IN(dbg_in),
    .DEBUG_DATA_PIN_OUT(dbg_out), .DEBUG_DATA_PIN_OE_N(dbg_oe_n));

  // 125 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Strobes are one cycle wide, so gather them here; one writer only
  always @(posedge mclk) begin
    if (clr) begin
      cmd_seen <= 4'h0;
      wr_cnt   <= 8'h00;
      rd_cnt   <= 8'h00;
    end else begin
      cmd_seen <= cmd_seen | flash_cmd;
      wr_cnt   <= wr_cnt + {7'h00, prog_wr_stb};
      rd_cnt   <= rd_cnt + {7'h00, prog_rd_stb};
    end
  end

  // ********************
  // Tasks and expectations
  // ********************
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t byte %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t flag %b expected %b", $time, g, e);
    end
  endtask

  // Let one clock edge empty the tallies
  task automatic clear();
    clr = 1'b1;
    @(negedge mclk);
    clr = 1'b0;
  endtask

  // One frame, then a bounded wait for the wire to be released
  task automatic xfer(input logic [1:0] ins, input logic [7:0] wd);
    int n;
    dbg_host_model_i.frame(ins, wd, got);
    n = 0;
    while (dbg_oe_n !== 1'b1 && n < 16) begin
      @(negedge mclk);
      n++;
    end
    if (dbg_oe_n !== 1'b1) begin
      fails++;
      report_and_stop();
    end else begin
      repeat (8) @(negedge mclk);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] sel, input logic [7:0] ctl);
    case (sel)
      `SEL_PART_IDENTITY:    return `PART_IDENTITY_VALUE;
      `SEL_SILICON_REVISION: return rev;
      `SEL_PROGRAM_CONTROL:  return ctl;
      `SEL_PROGRAM_DATA:     return prog_rdata;
      default:               return 8'h00;
    endcase
  endfunction

  function automatic logic [3:0] exp_cmd(input logic [7:0] b);
    case (b)
      `CMD_BLOCK_READ:   return 4'h1;
      `CMD_BLOCK_WRITE:  return 4'h2;
      `CMD_PAGE_ERASE:   return 4'h4;
      `CMD_DEVICE_ERASE: return 4'h8;
      default:           return 4'h0;
    endcase
  endfunction

  // Cut a hang short
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    seed = 46793;
    fails = 0;
    n_compared = 0;
    nrst = 1'b0;
    clr = 1'b1;
    cmd_expect = 1'b0;
    prog_rdata = 8'h00;
    rev = 8'($random(seed));
    tbl = '{`CMD_BLOCK_READ, `CMD_BLOCK_WRITE, `CMD_PAGE_ERASE, `CMD_DEVICE_ERASE};
    repeat (8) @(negedge mclk);
    cmp1(prog_mode, 1'b0);
    nrst = 1'b1;
    clr = 1'b0;
    repeat (4) @(negedge mclk);
    xfer(SEL_RD, 8'h00);
    cmp8(got, `SEL_RESET);
    clear();
    // Read-only places ignore writes
    for (int s = 0; s < 2; s++) begin
      xfer(SEL_WR, 8'(s));
      xfer(DAT_WR, ~exp_rd(8'(s), 8'h00));
      xfer(DAT_RD, 8'h00);
      cmp8(got, exp_rd(8'(s), 8'h00));
    end
    // Unlisted place reads zero, drops writes
    xfer(SEL_WR, 8'h55);
    xfer(DAT_WR, `CMD_BLOCK_WRITE);
    xfer(DAT_RD, 8'h00);
    cmp8(got, exp_rd(8'h55, 8'h00));
    cmp8(wr_cnt, 8'h00);
    // Select round trip, boundary then random
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      xfer(SEL_WR, v);
      xfer(SEL_RD, 8'h00);
      cmp8(got, v);
    end
    // Data port before unlock: byte passes, no command
    cmd_expect = 1'b1;
    xfer(SEL_WR, `SEL_PROGRAM_DATA);
    xfer(DAT_WR, `CMD_BLOCK_WRITE);
    cmp8(prog_wdata, `CMD_BLOCK_WRITE);
    cmp8({4'h0, cmd_seen}, 8'h00);
    // Interrupted unlock, then the proper pair
    xfer(SEL_WR, `SEL_PROGRAM_CONTROL);
    xfer(DAT_WR, `UNLOCK_FIRST);
    xfer(DAT_WR, 8'h05);
    xfer(DAT_WR, `UNLOCK_SECOND);
    cmp1(prog_mode, 1'b0);
    xfer(DAT_RD, 8'h00);
    cmp8(got, exp_rd(`SEL_PROGRAM_CONTROL, `UNLOCK_SECOND));
    xfer(DAT_WR, `UNLOCK_FIRST);
    xfer(DAT_WR, `UNLOCK_SECOND);
    cmp1(prog_mode, 1'b1);
    // Every command, a command while the engine expects none, a random byte
    xfer(SEL_WR, `SEL_PROGRAM_DATA);
    for (int i = 0; i < 6; i++) begin
      v = (i < 5) ? tbl[i % 4] : 8'($random(seed));
      cmd_expect = (i != 4);
      clear();
      xfer(DAT_WR, v);
      cmp8({4'h0, cmd_seen}, {4'h0, cmd_expect ? exp_cmd(v) : 4'h0});
      cmp8(prog_wdata, v);
      cmp8(wr_cnt, 8'h01);
    end
    // Data port read hands over the engine byte
    prog_rdata = 8'($random(seed));
    clear();
    xfer(DAT_RD, 8'h00);
    cmp8(got, exp_rd(`SEL_PROGRAM_DATA, 8'h00));
    cmp8(rd_cnt, 8'h01);
    // Mode survives control writes, leaves only at reset
    xfer(SEL_WR, `SEL_PROGRAM_CONTROL);
    xfer(DAT_WR, 8'h00);
    cmp1(prog_mode, 1'b1);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    cmp1(prog_mode, 1'b0);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    xfer(SEL_RD, 8'h00);
    cmp8(got, `SEL_RESET);
    report_and_stop();
  end
endmodule
